// ### common/output_map_pkg.sv
// Purpose: constants shared by the output terminal mapper
// Assumes: 50 MHz system clock, Avalon-MM register access
// Notes: scaled units: percent in 0.01 %, delays in 0.1 s, filter times in 0.01 s, pulse freq in 0.01 kHz
package output_map_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int DELAY_STEP_NS = 100_000_000;
  localparam int FILTER_STEP_NS = 10_000_000;
  localparam int PULSE_UNIT_HZ = 10;
  localparam int NS_PER_S = 1_000_000_000;
  localparam logic [23:0] PULSE_HALF_ACC = 24'((NS_PER_S / CLK_PERIOD_NS) / (2 * PULSE_UNIT_HZ));

  // bus
  localparam int ADDR_W = 8;
  localparam int REG_BYTE_SHIFT = 2;
  localparam int NUM_REGS = 21;

  // register indexes (byte address = index * 4)
  localparam logic [4:0] R_CTRL = 5'h00;
  localparam logic [4:0] R_SEL = 5'h01;
  localparam logic [4:0] R_POL = 5'h02;
  localparam logic [4:0] R_DLY0 = 5'h03;
  localparam logic [4:0] R_SRC = 5'h07;
  localparam logic [4:0] R_AO1 = 5'h08;
  localparam logic [4:0] R_AO2 = 5'h09;
  localparam logic [4:0] R_FLT0 = 5'h0a;
  localparam logic [4:0] R_PMAX = 5'h0d;
  localparam logic [4:0] R_PON = 5'h0e;
  localparam logic [4:0] R_TSET = 5'h0f;
  localparam logic [4:0] R_RUNLIM = 5'h10;
  localparam logic [4:0] R_AILIM = 5'h11;
  localparam logic [4:0] R_TEMP = 5'h12;
  localparam logic [4:0] R_STAT = 5'h13;
  localparam logic [4:0] R_LEVEL = 5'h14;

  // control bits
  localparam int CTRL_PULSE_MODE = 0;
  localparam int CTRL_AO1_CURRENT = 1;
  localparam int CTRL_AO2_CURRENT = 2;
  localparam int CTRL_TIMING_EN = 3;

  localparam logic [31:0] REG_RESET [NUM_REGS] = '{
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_0100,
    32'h0000_0064, 32'h0000_0064, 32'h0, 32'h0, 32'h0, 32'h0000_1388,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  localparam logic [31:0] REG_MASK [NUM_REGS] = '{
    32'h0000_000f, 32'h3f3f_3f3f, 32'h0000_1111, 32'h0000_ffff, 32'h0000_ffff,
    32'h0000_ffff, 32'h0000_ffff, 32'h0000_0fff, 32'hffff_ffff, 32'hffff_ffff,
    32'h0000_03ff, 32'h0000_03ff, 32'h0000_03ff, 32'h0000_3fff, 32'h0000_ffff,
    32'h0000_ffff, 32'h0000_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'h0, 32'h0};

  // digital output selector codes
  localparam logic [5:0] SEL_POWER_ON = 6'h18;
  localparam logic [5:0] SEL_FREQ_LEVEL_DETECT_TWO = 6'h19;
  localparam logic [5:0] SEL_FREQ1 = 6'h1a;
  localparam logic [5:0] SEL_FREQ2 = 6'h1b;
  localparam logic [5:0] SEL_CUR1 = 6'h1c;
  localparam logic [5:0] SEL_CUR2 = 6'h1d;
  localparam logic [5:0] SEL_TIMING = 6'h1e;
  localparam logic [5:0] SEL_AI1_LIMIT = 6'h1f;
  localparam logic [5:0] SEL_LOAD_ZERO = 6'h20;
  localparam logic [5:0] SEL_REVERSE = 6'h21;
  localparam logic [5:0] SEL_ZERO_CUR = 6'h22;
  localparam logic [5:0] SEL_MODULE_TEMP = 6'h23;
  localparam logic [5:0] SEL_CUR_LIMIT = 6'h24;
  localparam logic [5:0] SEL_LOWER_LIMIT = 6'h25;
  localparam logic [5:0] SEL_ALARM_RUN = 6'h26;
  localparam logic [5:0] SEL_MOTOR_HOT = 6'h27;
  localparam logic [5:0] SEL_RUN_TIME = 6'h28;

  // analog source codes
  localparam logic [3:0] SRC_SET_FREQ = 4'h0;
  localparam logic [3:0] SRC_RUN_FREQ = 4'h1;
  localparam logic [3:0] SRC_CURRENT = 4'h2;
  localparam logic [3:0] SRC_VOLTAGE = 4'h3;
  localparam logic [3:0] SRC_SPEED = 4'h4;
  localparam logic [3:0] SRC_TORQUE = 4'h5;
  localparam logic [3:0] SRC_POWER = 4'h6;
  localparam logic [3:0] SRC_PULSE_IN = 4'h7;
  localparam logic [3:0] SRC_AI1 = 4'h8;
  localparam logic [3:0] SRC_AI2 = 4'h9;
  localparam logic [3:0] SRC_AI3 = 4'ha;
  localparam logic [3:0] SRC_LENGTH = 4'hb;
  localparam logic [3:0] SRC_COUNT = 4'hc;
  localparam logic [3:0] SRC_COMM = 4'hd;
  localparam logic [3:0] SRC_AMPS = 4'he;
  localparam logic [3:0] SRC_VOLTS = 4'hf;

  // scaling
  localparam logic [13:0] PCT_FULL = 14'h2710;
  localparam logic [17:0] TWICE = 18'h2;
  localparam logic [17:0] VOLT_NUM = 18'hc;
  localparam logic [17:0] VOLT_DEN = 18'ha;
  localparam logic [17:0] AI_FULL = 18'h3e8;
  localparam logic [17:0] PULSE_IN_FULL = 18'h2710;
  localparam logic [17:0] COMM_FULL = 18'h3e8;
  localparam logic [17:0] KILO_FULL = 18'h2710;
  localparam int GAIN_UNIT = 100;
  localparam int OFFSET_TO_LEVEL = 10;
  localparam logic signed [15:0] GAIN_LIM = 16'sh03e8;
  localparam logic signed [15:0] OFFSET_LIM = 16'sh03e8;
  localparam logic [13:0] PULSE_MIN = 14'h0001;
  localparam logic [13:0] PULSE_MAX_LIM = 14'h2710;
  localparam logic [15:0] DELAY_MAX = 16'h8ca0;
  localparam logic [9:0] FILTER_MAX = 10'h3e8;

endpackage

// ### src/drive_output_terminal_mapper.sv
// Purpose: maps drive status onto digital, pulse and analog output terminals
// Assumes: status inputs synchronous to clock; Avalon-MM slave, one wait state
// Notes:
// Contract
// - selector 24 on power-on hours past threshold
// - selector 30 on timed run reaching set
// - selector 31 on analog input outside limits
// - selector 32 on while load is zero
// - selector 33 on while running reverse
// - selector 35 on heatsink at threshold
// - selector 37 lower limit, held at stop
// - selector 38 alarm while fault keeps running
// - selector 39 on motor temperature warning
// - selector 40 on present run past limit
// - selectors 25-29, 34, 36 pass detectors through
// - polarity digits: pulse, relay, relay, collector
// - polarity one inverts the output contact
// - per-output delay 0 to 3600 s
// - pulse frequency 0.01 kHz to set maximum
// - source selector picks quantity and full scale
// - analog value is gain times standard plus offset
// - offset 100 percent equals full scale
// - each analog and pulse output filtered
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ns

module drive_output_terminal_mapper #(
  parameter int DELAY_STEP_CYC = output_map_pkg::DELAY_STEP_NS / output_map_pkg::CLK_PERIOD_NS,
  parameter int FILTER_STEP_CYC = output_map_pkg::FILTER_STEP_NS / output_map_pkg::CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // register bus
  input wire logic [output_map_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // drive status
  input wire logic [15:0] power_on_hours,
  input wire logic [15:0] run_minutes,
  input wire logic load_zero,
  input wire logic reverse_running,
  input wire logic [15:0] heatsink_temp,
  input wire logic at_lower_limit,
  input wire logic drive_stopped,
  input wire logic fault_keep_running,
  input wire logic [15:0] motor_temp,
  // detectors configured elsewhere
  input wire logic freq_level_detect_two,
  input wire logic freq_one_reached,
  input wire logic freq_two_reached,
  input wire logic current_one_reached,
  input wire logic current_two_reached,
  input wire logic zero_current,
  input wire logic current_limit_hit,
  // quantities
  input wire logic [15:0] set_freq,
  input wire logic [15:0] run_freq,
  input wire logic [15:0] out_current,
  input wire logic [15:0] out_voltage,
  input wire logic [15:0] out_speed,
  input wire logic [15:0] out_torque,
  input wire logic [15:0] out_power,
  input wire logic [15:0] pulse_in_freq,
  input wire logic [15:0] analog_in_one,
  input wire logic [15:0] analog_in_two,
  input wire logic [15:0] analog_in_three,
  input wire logic [15:0] length_value,
  input wire logic [15:0] count_value,
  input wire logic [15:0] comm_setting,
  input wire logic [15:0] current_amps,
  input wire logic [15:0] voltage_volts,
  // full scales
  input wire logic [15:0] max_freq,
  input wire logic [15:0] rated_current,
  input wire logic [15:0] rated_voltage,
  input wire logic [15:0] speed_at_max,
  input wire logic [15:0] rated_torque,
  input wire logic [15:0] rated_power,
  input wire logic [15:0] max_length,
  input wire logic [15:0] max_count,
  // terminals
  output logic fast_pulse_terminal,
  output logic first_relay,
  output logic second_relay,
  output logic open_collector_out,
  output logic [13:0] analog_out_one,
  output logic [13:0] analog_out_two,
  output logic analog_out_one_current,
  output logic analog_out_two_current
);
  import output_map_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [13:0] norm_f(input logic [15:0] v, input logic [17:0] fs);
    logic [33:0] q;
    q = 34'h0;
    if (fs != 18'h0) q = (34'(v) * 34'(PCT_FULL)) / 34'(fs);
    return (q > 34'(PCT_FULL)) ? PCT_FULL : q[13:0];
  endfunction

  function automatic logic [15:0] src_val_f(input logic [3:0] s);
    logic [15:0] v;
    unique case (s)
      SRC_SET_FREQ: v = set_freq;
      SRC_RUN_FREQ: v = run_freq;
      SRC_CURRENT: v = out_current;
      SRC_VOLTAGE: v = out_voltage;
      SRC_SPEED: v = out_speed;
      SRC_TORQUE: v = out_torque;
      SRC_POWER: v = out_power;
      SRC_PULSE_IN: v = pulse_in_freq;
      SRC_AI1: v = analog_in_one;
      SRC_AI2: v = analog_in_two;
      SRC_AI3: v = analog_in_three;
      SRC_LENGTH: v = length_value;
      SRC_COUNT: v = count_value;
      SRC_COMM: v = comm_setting;
      SRC_AMPS: v = current_amps;
      SRC_VOLTS: v = voltage_volts;
    endcase
    return v;
  endfunction

  function automatic logic [17:0] src_fs_f(input logic [3:0] s);
    logic [17:0] f;
    unique case (s)
      SRC_SET_FREQ, SRC_RUN_FREQ: f = 18'(max_freq);
      SRC_CURRENT: f = 18'(rated_current) * TWICE;
      SRC_VOLTAGE: f = 18'((20'(rated_voltage) * 20'(VOLT_NUM)) / 20'(VOLT_DEN));
      SRC_SPEED: f = 18'(speed_at_max);
      SRC_TORQUE: f = 18'(rated_torque) * TWICE;
      SRC_POWER: f = 18'(rated_power) * TWICE;
      SRC_PULSE_IN: f = PULSE_IN_FULL;
      SRC_AI1, SRC_AI2, SRC_AI3: f = AI_FULL;
      SRC_LENGTH: f = 18'(max_length);
      SRC_COUNT: f = 18'(max_count);
      SRC_COMM: f = COMM_FULL;
      SRC_AMPS, SRC_VOLTS: f = KILO_FULL;
    endcase
    return f;
  endfunction

  // filter: one step of a first-order lag, time constant in 10 ms steps
  function automatic logic [13:0] filt_f(input logic [13:0] y, input logic [13:0] x,
                                         input logic [9:0] t);
    logic signed [15:0] d;
    logic [9:0] tc;
    tc = (t > FILTER_MAX) ? FILTER_MAX : t;
    d = 16'(signed'({2'b00, x}) - signed'({2'b00, y}));
    return 14'(signed'({2'b00, y}) + d / signed'({6'h0, tc} + 16'sh0001));
  endfunction

  function automatic logic [13:0] analog_f(input logic [13:0] x, input logic [31:0] cfg);
    logic signed [15:0] k;
    logic signed [15:0] b;
    logic signed [31:0] y;
    k = signed'(cfg[15:0]);
    b = signed'(cfg[31:16]);
    k = (k > GAIN_LIM) ? GAIN_LIM : ((k < -GAIN_LIM) ? -GAIN_LIM : k);
    b = (b > OFFSET_LIM) ? OFFSET_LIM : ((b < -OFFSET_LIM) ? -OFFSET_LIM : b);
    y = (32'(k) * signed'({18'h0, x})) / GAIN_UNIT + 32'(b) * OFFSET_TO_LEVEL;
    if (y < 0) return 14'h0;
    return (y > signed'({18'h0, PCT_FULL})) ? PCT_FULL : y[13:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register bus: every access takes one wait state

  logic [31:0] regs_r [NUM_REGS];
  logic ack_r;
  wire [4:0] idx = avs_address[REG_BYTE_SHIFT +: 5];
  wire mapped = (32'(idx) < NUM_REGS);
  wire wr_go = avs_write && !avs_waitrequest;
  wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

  always_ff @(posedge clock) begin
    if (!resetn) ack_r <= 1'b0;
    else ack_r <= (avs_read || avs_write) && !ack_r;
  end

  logic [31:0] status_w;
  logic [31:0] level_w;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack_r) begin
      if (!mapped) avs_readdata <= 32'h0;
      else if (idx == R_STAT) avs_readdata <= status_w;
      else if (idx == R_LEVEL) avs_readdata <= level_w;
      else avs_readdata <= regs_r[idx];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_REGS; i++) regs_r[i] <= REG_RESET[i];
    end else if (wr_go && mapped) begin
      regs_r[idx] <= (regs_r[idx] & ~(be_mask & REG_MASK[idx]))
                   | (avs_writedata & be_mask & REG_MASK[idx]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field decode

  wire [3:0] ctrl = regs_r[R_CTRL][3:0];
  wire [15:0] pol_setting = regs_r[R_POL][15:0];
  wire [3:0] src_pulse = regs_r[R_SRC][3:0];
  wire [3:0] src_ao1 = regs_r[R_SRC][7:4];
  wire [3:0] src_ao2 = regs_r[R_SRC][11:8];
  wire [13:0] pmax_raw = regs_r[R_PMAX][13:0];
  wire [13:0] pmax = (pmax_raw < PULSE_MIN) ? PULSE_MIN :
                     ((pmax_raw > PULSE_MAX_LIM) ? PULSE_MAX_LIM : pmax_raw);
  wire [15:0] ai1_lower = regs_r[R_AILIM][15:0];
  wire [15:0] ai1_upper = regs_r[R_AILIM][31:16];
  wire [15:0] module_thr = regs_r[R_TEMP][15:0];
  wire [15:0] motor_thr = regs_r[R_TEMP][31:16];

  assign analog_out_one_current = ctrl[CTRL_AO1_CURRENT];
  assign analog_out_two_current = ctrl[CTRL_AO2_CURRENT];

  function automatic logic cond_f(input logic [5:0] s);
    logic c;
    c = 1'b0;
    unique case (s)
      SEL_POWER_ON: c = power_on_hours > regs_r[R_PON][15:0];
      SEL_TIMING: c = ctrl[CTRL_TIMING_EN] && (run_minutes >= regs_r[R_TSET][15:0]);
      SEL_AI1_LIMIT: c = (analog_in_one > ai1_upper) || (analog_in_one < ai1_lower);
      SEL_LOAD_ZERO: c = load_zero;
      SEL_REVERSE: c = reverse_running;
      SEL_MODULE_TEMP: c = heatsink_temp >= module_thr;
      SEL_LOWER_LIMIT: c = at_lower_limit || drive_stopped;
      SEL_ALARM_RUN: c = fault_keep_running;
      SEL_MOTOR_HOT: c = motor_temp >= motor_thr;
      SEL_RUN_TIME: c = run_minutes > regs_r[R_RUNLIM][15:0];
      SEL_FREQ_LEVEL_DETECT_TWO: c = freq_level_detect_two;
      SEL_FREQ1: c = freq_one_reached;
      SEL_FREQ2: c = freq_two_reached;
      SEL_CUR1: c = current_one_reached;
      SEL_CUR2: c = current_two_reached;
      SEL_ZERO_CUR: c = zero_current;
      SEL_CUR_LIMIT: c = current_limit_hit;
      default: c = 1'b0;
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // time bases

  logic [31:0] dly_cnt_r;
  logic [31:0] flt_cnt_r;
  wire dly_tick = (dly_cnt_r == 32'(DELAY_STEP_CYC - 1));
  wire flt_tick = (flt_cnt_r == 32'(FILTER_STEP_CYC - 1));

  always_ff @(posedge clock) begin
    if (!resetn) begin
      dly_cnt_r <= 32'h0;
      flt_cnt_r <= 32'h0;
    end else begin
      dly_cnt_r <= dly_tick ? 32'h0 : dly_cnt_r + 32'h1;
      flt_cnt_r <= flt_tick ? 32'h0 : flt_cnt_r + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // digital outputs: 0 pulse terminal, 1 first relay, 2 second relay, 3 collector

  logic raw_w [4];
  logic applied_r [4];
  logic term_r [4];
  logic [15:0] hold_r [4];
  logic [15:0] delay_w [4];
  logic pol_w [4];

  for (genvar g = 0; g < 4; g++) begin : g_dout
    assign raw_w[g] = cond_f(regs_r[R_SEL][8*g +: 6]);
    assign delay_w[g] = (regs_r[R_DLY0 + 5'(g)][15:0] > DELAY_MAX) ? DELAY_MAX
                      : regs_r[R_DLY0 + 5'(g)][15:0];
    assign pol_w[g] = pol_setting[4*g];

    // a change that reverts before its delay expires never reaches the pin
    always_ff @(posedge clock) begin
      if (!resetn) begin
        applied_r[g] <= 1'b0;
        hold_r[g] <= 16'h0;
      end else if (raw_w[g] == applied_r[g]) begin
        hold_r[g] <= 16'h0;
      end else if (hold_r[g] >= delay_w[g]) begin
        applied_r[g] <= raw_w[g];
        hold_r[g] <= 16'h0;
      end else if (dly_tick) begin
        hold_r[g] <= hold_r[g] + 16'h1;
      end
    end

    always_ff @(posedge clock) begin
      if (!resetn) term_r[g] <= 1'b0;
      else term_r[g] <= applied_r[g] ^ pol_w[g];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog and pulse outputs

  wire [13:0] std_pulse = norm_f(src_val_f(src_pulse), src_fs_f(src_pulse));
  wire [13:0] std_ao1 = norm_f(src_val_f(src_ao1), src_fs_f(src_ao1));
  wire [13:0] std_ao2 = norm_f(src_val_f(src_ao2), src_fs_f(src_ao2));
  wire [13:0] want_ao1 = analog_f(std_ao1, regs_r[R_AO1]);
  wire [13:0] want_ao2 = analog_f(std_ao2, regs_r[R_AO2]);
  logic [13:0] filt_pulse_r;
  logic [13:0] pulse_freq_r;
  logic [23:0] acc_r;
  logic wave_r;
  wire [27:0] span = 28'(filt_pulse_r) * 28'(pmax - PULSE_MIN);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      analog_out_one <= 14'h0;
      analog_out_two <= 14'h0;
      filt_pulse_r <= 14'h0;
    end else if (flt_tick) begin
      analog_out_one <= filt_f(analog_out_one, want_ao1, regs_r[R_FLT0][9:0]);
      analog_out_two <= filt_f(analog_out_two, want_ao2, regs_r[R_FLT0 + 5'h1][9:0]);
      filt_pulse_r <= filt_f(filt_pulse_r, std_pulse, regs_r[R_FLT0 + 5'h2][9:0]);
    end
  end

  // phase accumulator: toggles the wave every half period at pulse_freq_r
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pulse_freq_r <= PULSE_MIN;
      acc_r <= 24'h0;
      wave_r <= 1'b0;
    end else begin
      pulse_freq_r <= PULSE_MIN + 14'(span / 28'(PCT_FULL));
      if (acc_r + 24'(pulse_freq_r) >= PULSE_HALF_ACC) begin
        acc_r <= acc_r + 24'(pulse_freq_r) - PULSE_HALF_ACC;
        wave_r <= !wave_r;
      end else begin
        acc_r <= acc_r + 24'(pulse_freq_r);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) fast_pulse_terminal <= 1'b0;
    else fast_pulse_terminal <= ctrl[CTRL_PULSE_MODE] ? wave_r : term_r[0];
  end

  assign first_relay = term_r[1];
  assign second_relay = term_r[2];
  assign open_collector_out = term_r[3];

  assign status_w = {2'b00, pulse_freq_r, 4'h0,
                     term_r[3], term_r[2], term_r[1], term_r[0],
                     applied_r[3], applied_r[2], applied_r[1], applied_r[0],
                     raw_w[3], raw_w[2], raw_w[1], raw_w[0]};
  assign level_w = {2'b00, analog_out_two, 2'b00, analog_out_one};

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  wire [5:0] sel0 = regs_r[R_SEL][5:0];
  wire [5:0] sel1 = regs_r[R_SEL][13:8];

  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
                                 |=> !avs_waitrequest) else $error("no answer after wait");
  power_on_sel_a: assert property (sel0 == SEL_POWER_ON && power_on_hours >
      regs_r[R_PON][15:0] |-> raw_w[0]) else $error("power-on flag missing");
  ai_limit_sel_a: assert property (sel1 == SEL_AI1_LIMIT && analog_in_one <= ai1_upper
      && analog_in_one >= ai1_lower |-> !raw_w[1]) else $error("ai limit false hit");
  lower_stop_a: assert property (sel0 == SEL_LOWER_LIMIT && drive_stopped |-> raw_w[0])
      else $error("lower limit dropped at stop");
  undefined_sel_a: assert property (sel0 < SEL_POWER_ON |-> !raw_w[0])
      else $error("undefined selector active");
  polarity_out_a: assert property (##1 first_relay == ($past(applied_r[1]) ^
      $past(pol_w[1]))) else $error("relay polarity wrong");
  zero_delay_a: assert property (delay_w[2] == 16'h0 && raw_w[2] != applied_r[2]
      |=> applied_r[2] == $past(raw_w[2])) else $error("zero delay late");
  early_change_a: assert property (raw_w[3] != applied_r[3] && hold_r[3] < delay_w[3]
      |=> $stable(applied_r[3])) else $error("output changed before delay");
  // the rate register lags a lowered maximum by one cycle
  pulse_range_a: assert property (##1 pulse_freq_r >= PULSE_MIN
      && pulse_freq_r <= $past(pmax)) else $error("pulse frequency out of range");
  analog_range_a: assert property (analog_out_one <= PCT_FULL
      && analog_out_two <= PCT_FULL) else $error("analog level over full scale");

endmodule // drive_output_terminal_mapper

// ### verif/drive_output_terminal_mapper_tb.sv
// Purpose: self-checking bench for the output terminal mapper
// Assumes: one wait state per bus access; short delay and filter steps
// Notes: status inputs are random around the thresholds written at start
`timescale 1ns/1ns

module drive_output_terminal_mapper_tb;
  logic clock, resetn, avs_read, avs_write, avs_waitrequest, e;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable, p;
  logic [15:0] power_on_hours, run_minutes, heatsink_temp, motor_temp, set_freq, run_freq;
  logic [15:0] out_current, out_voltage, out_speed, out_torque, out_power, pulse_in_freq;
  logic [15:0] analog_in_one, analog_in_two, analog_in_three, length_value, count_value;
  logic [15:0] comm_setting, current_amps, voltage_volts, max_freq, rated_current;
  logic [15:0] rated_voltage, speed_at_max, rated_torque, rated_power, max_length, max_count;
  logic load_zero, reverse_running, at_lower_limit, drive_stopped, fault_keep_running;
  logic freq_level_detect_two, freq_one_reached, freq_two_reached, current_one_reached;
  logic current_two_reached, zero_current, current_limit_hit;
  logic fast_pulse_terminal, first_relay, second_relay, open_collector_out;
  logic analog_out_one_current, analog_out_two_current;
  logic [13:0] analog_out_one, analog_out_two;
  int error_cnt = 0, checks = 0, cyc = 0, c0, closures;
  integer seed = 32'ha823;

  drive_output_terminal_mapper #(.DELAY_STEP_CYC(4), .FILTER_STEP_CYC(2))
    drive_output_terminal_mapper_inst (.*);
  terminal_load terminal_load_inst (.clock(clock), .contact(first_relay), .closures(closures));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    checks++;
    if (sn !== ex) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, sn);
    end
  endtask

  // request stands until an edge samples waitrequest low; an idle cycle separates calls
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic rnd;
    power_on_hours <= 16'($random(seed)) & 16'hff;
    run_minutes <= 16'($random(seed)) & 16'h7f;
    heatsink_temp <= 16'($random(seed)) & 16'h3ff;
    motor_temp <= 16'($random(seed)) & 16'h3ff;
    analog_in_one <= 16'($random(seed)) & 16'h3ff;
    {set_freq, run_freq} <= $random(seed) & 32'h0fff0fff;
    {out_current, out_voltage, out_speed, out_torque} <= {$random(seed), $random(seed)};
    {pulse_in_freq, analog_in_two, analog_in_three, length_value, count_value,
     comm_setting} <= {$random(seed), $random(seed), $random(seed)};
    {current_amps, voltage_volts} <= $random(seed);
    out_power <= 16'($random(seed));
    {load_zero, reverse_running, at_lower_limit, drive_stopped, fault_keep_running,
     freq_level_detect_two, freq_one_reached, freq_two_reached, current_one_reached,
     current_two_reached, zero_current, current_limit_hit} <= 12'($random(seed));
  endtask

  // reference condition for one selector code
  function automatic logic fx(input int s);
    case (s)
      24: return power_on_hours > 16'd100;
      25: return freq_level_detect_two;
      26: return freq_one_reached;
      27: return freq_two_reached;
      28: return current_one_reached;
      29: return current_two_reached;
      30: return run_minutes >= 16'd50;
      31: return analog_in_one > 16'd800 || analog_in_one < 16'd200;
      32: return load_zero;
      33: return reverse_running;
      34: return zero_current;
      35: return heatsink_temp >= 16'd500;
      36: return current_limit_hit;
      37: return at_lower_limit || drive_stopped;
      38: return fault_keep_running;
      39: return motor_temp >= 16'd400;
      40: return run_minutes > 16'd60;
      default: return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      close_out;
    end
  end

  initial begin
    resetn <= 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} <= '0;
    avs_byteenable <= 4'hf;
    max_freq <= 16'd5000;
    {rated_current, rated_voltage, speed_at_max, rated_torque, rated_power, max_length,
     max_count} <= {7{16'h1000}};
    rnd;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    bus(0, 8'h1c, 0, rd); chk("src reset", 32'h100, rd);
    bus(0, 8'h34, 0, rd); chk("pulse max reset", 32'h1388, rd);
    bus(0, 8'h20, 0, rd); chk("ao1 reset", 32'h64, rd);
    bus(0, 8'h0c, 0, rd); chk("delay reset", 32'h0, rd);
    bus(1, 8'h7c, 32'hffff_ffff, rd);
    bus(0, 8'h7c, 0, rd); chk("unmapped", 32'h0, rd);
    bus(1, 8'h00, 32'h8, rd);
    bus(1, 8'h38, 32'd100, rd);
    bus(1, 8'h3c, 32'd50, rd);
    bus(1, 8'h40, 32'd60, rd);
    bus(1, 8'h44, 32'h0320_00c8, rd);
    bus(1, 8'h48, 32'h0190_01f4, rd);
    // every code 23..41 on all four terminals with a random polarity per digit
    for (int s = 23; s <= 41; s++) repeat (3) begin
      bus(1, 8'h04, {4{2'b00, 6'(s)}}, rd);
      p = 4'($random(seed));
      bus(1, 8'h08, {16'h0, 3'b0, p[3], 3'b0, p[2], 3'b0, p[1], 3'b0, p[0]}, rd);
      rnd;
      settle(4);
      e = fx(s);
      chk("terminals", {28'h0, {4{e}} ^ p}, {28'h0, open_collector_out, second_relay,
          first_relay, fast_pulse_terminal});
    end
    bus(1, 8'h00, 32'ha, rd);
    bus(1, 8'h24, 32'h03e8_0000, rd);
    settle(10);
    chk("ao1 level", {16'h0, set_freq} * 2, {18'h0, analog_out_one});
    chk("ao2 level", 32'd10000, {18'h0, analog_out_two});
    chk("ao1 mode", 32'h1, {31'h0, analog_out_one_current});
    chk("ao2 mode", 32'h0, {31'h0, analog_out_two_current});
    bus(1, 8'h20, 32'h0320_ffce, rd);
    settle(10);
    chk("ao1 curve", 32'd8000 - {16'h0, set_freq}, {18'h0, analog_out_one});
    // relay one waits three delay steps while the collector follows at once
    bus(1, 8'h04, 32'h2121_2121, rd);
    bus(1, 8'h08, 32'h0, rd);
    bus(1, 8'h10, 32'd3, rd);
    reverse_running <= 1'b0;
    settle(24);
    c0 = closures;
    @(posedge clock);
    reverse_running <= 1'b1;
    settle(8);
    chk("relay early", 32'h0, {31'h0, first_relay});
    chk("collector", 32'h1, {31'h0, open_collector_out});
    settle(24);
    chk("relay late", 32'h1, {31'h0, first_relay});
    chk("closures", c0 + 1, closures);
    // pulse mode at full scale and 100.00 kHz: the pin toggles every 250 cycles
    bus(1, 8'h34, 32'd10000, rd);
    analog_in_one <= 16'd1000;
    bus(1, 8'h1c, 32'h108, rd);
    bus(1, 8'h00, 32'h1, rd);
    settle(20);
    @(posedge fast_pulse_terminal);
    @(negedge fast_pulse_terminal);
    @(negedge clock);
    c0 = cyc;
    @(posedge fast_pulse_terminal);
    @(negedge clock);
    chk("half period", 32'd250, 32'(cyc - c0));
    close_out;
  end
endmodule // drive_output_terminal_mapper_tb

// ### verif/terminal_load.sv
// Purpose: external equipment wired to one relay contact
// Assumes: contact level 1 means closed to common_return
// Notes: counts closures so the bench sees every closing of the contact, not only levels
`timescale 1ns/1ns

module terminal_load (
  // terminal
  input wire logic clock,
  input wire logic contact,
  // observation
  output int closures
);
  logic last_r = 1'b0;
  int count_r = 0;

  assign closures = count_r;

  always @(posedge clock) begin
    if (contact === 1'b1 && last_r === 1'b0) count_r <= count_r + 1;
    last_r <= contact;
  end
endmodule // terminal_load
